// [hdl/spi_master_clock_select_timing.sv]
/*
 * Master side serial clock generation and select sequencing, clock phase
 * one, with a transmit FIFO ahead of the shifter.
 * Assumes REF_CLK_I is the low-speed peripheral clock and that all inputs
 * are synchronous to it.
 */
`include "spi_timing_cfg.svh"

// Summary of operation
// - Serial period is four or divider plus one.
// - Period spans 4..128, or 5..127 when odd.
// - Odd period: first phase half cycle shorter.
// - Run only with master and phase-one bits set.
// - Polarity bit chooses idle and active clock levels.
// - Select asserts half period before first edge.
// - Select releases half period after last sample.
// - Select stays low across back-to-back words.
module spi_master_clock_select_timing #(
  parameter int WORD_W     = `WORD_WIDTH_DEFAULT,
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEFAULT
) (
  input  wire logic              REF_CLK_I,
  input  wire logic              RST_B_I,
  input  wire logic [7:0]        OPERATION_CONTROL_REG_I,
  input  wire logic [7:0]        CONFIGURATION_CONTROL_REG_I,
  input  wire logic [6:0]        BAUD_DIVIDER_I,
  input  wire logic [WORD_W-1:0] TX_DATA_I,
  input  wire logic              TX_VALID_I,
  output logic                   TX_READY_O,
  output logic [WORD_W-1:0]      RX_DATA_O,
  output logic                   RX_VALID_O,
  output logic                   BUSY_O,
  output logic                   SERIAL_CLOCK_PIN_O,
  output logic                   MASTER_OUT_PIN_O,
  input  wire logic              MASTER_IN_PIN_I,
  output logic                   SLAVE_SELECT_PIN_B_O
);

  localparam int BW = $clog2(WORD_W + 1);

  word_stream_if #(.WIDTH(WORD_W)) tx_fill ();
  word_stream_if #(.WIDTH(WORD_W)) tx_drain ();

  word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i   (REF_CLK_I),
    .rst_b_i (RST_B_I),
    .fill    (tx_fill.snk),
    .drain   (tx_drain.src)
  );

  assign tx_fill.valid = TX_VALID_I;
  assign tx_fill.data  = TX_DATA_I;
  assign TX_READY_O    = tx_fill.ready;

  // Control bits.
  logic master_en;
  logic phase_one;
  logic polarity;
  logic run_en;

  assign master_en = OPERATION_CONTROL_REG_I[`OPCTL_MASTER_BIT];
  assign phase_one = OPERATION_CONTROL_REG_I[`OPCTL_PHASE_BIT];
  assign polarity  = CONFIGURATION_CONTROL_REG_I[`CFGCTL_POLARITY_BIT];
  assign run_en    = master_en & phase_one;

  // Period from the divider setting.
  spi_timing_pkg::period_t period_sel;
  spi_timing_pkg::period_t first_len_sel;
  spi_timing_pkg::period_t second_len_sel;

  always_comb begin
    if (BAUD_DIVIDER_I <= `DIVIDER_FIXED_LIMIT) begin
      period_sel = `SERIAL_PERIOD_FIXED;
    end else begin
      period_sel = {1'b0, BAUD_DIVIDER_I} + 8'h01;
    end
    // An odd period puts the spare cycle into the second phase.
    first_len_sel  = period_sel >> 1;
    second_len_sel = period_sel - first_len_sel;
  end

  // Sequencer state.
  spi_timing_pkg::seq_state_e state_r;
  spi_timing_pkg::seq_state_e state_nxt;
  spi_timing_pkg::period_t    cnt_r;
  spi_timing_pkg::period_t    cnt_nxt;
  spi_timing_pkg::period_t    first_len_r;
  spi_timing_pkg::period_t    first_len_nxt;
  spi_timing_pkg::period_t    second_len_r;
  spi_timing_pkg::period_t    second_len_nxt;
  logic                       pol_r;
  logic                       pol_nxt;
  logic [BW-1:0]              bits_r;
  logic [BW-1:0]              bits_nxt;
  logic [WORD_W-1:0]          tx_sh_r;
  logic [WORD_W-1:0]          tx_sh_nxt;
  logic [WORD_W-1:0]          rx_sh_r;
  logic [WORD_W-1:0]          rx_sh_nxt;
  logic [WORD_W-1:0]          rx_data_r;
  logic [WORD_W-1:0]          rx_data_nxt;
  logic                       rx_valid_r;
  logic                       rx_valid_nxt;
  logic                       sclk_r;
  logic                       sclk_nxt;
  logic                       mosi_r;
  logic                       mosi_nxt;
  logic                       sel_b_r;
  logic                       sel_b_nxt;
  logic                       pop;
  logic                       last_bit;
  logic                       cnt_done;

  assign cnt_done = (cnt_r == 8'h01);
  assign last_bit = (bits_r == BW'(1));

  always_comb begin
    state_nxt      = state_r;
    cnt_nxt        = cnt_r;
    first_len_nxt  = first_len_r;
    second_len_nxt = second_len_r;
    pol_nxt        = pol_r;
    bits_nxt       = bits_r;
    tx_sh_nxt      = tx_sh_r;
    rx_sh_nxt      = rx_sh_r;
    rx_data_nxt    = rx_data_r;
    rx_valid_nxt   = 1'b0;
    sclk_nxt       = sclk_r;
    mosi_nxt       = mosi_r;
    sel_b_nxt      = sel_b_r;
    pop            = 1'b0;
    case (state_r)
      spi_timing_pkg::ST_IDLE: begin
        sclk_nxt  = polarity;
        sel_b_nxt = `SELECT_IDLE_LEVEL;
        if (run_en && tx_drain.valid) begin
          pop            = 1'b1;
          first_len_nxt  = first_len_sel;
          second_len_nxt = second_len_sel;
          pol_nxt        = polarity;
          tx_sh_nxt      = tx_drain.data << 1;
          mosi_nxt       = tx_drain.data[WORD_W-1];
          bits_nxt       = BW'(WORD_W);
          sel_b_nxt      = 1'b0;
          // The lead lasts the longer half, never less than half a period.
          cnt_nxt        = second_len_sel;
          state_nxt      = spi_timing_pkg::ST_LEAD;
        end
      end
      spi_timing_pkg::ST_LEAD: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_done) begin
          // First edge samples the bit driven a half period ago.
          sclk_nxt  = ~pol_r;
          rx_sh_nxt = {rx_sh_r[WORD_W-2:0], MASTER_IN_PIN_I};
          cnt_nxt   = first_len_r;
          state_nxt = spi_timing_pkg::ST_FIRST;
        end
      end
      spi_timing_pkg::ST_FIRST: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_done) begin
          sclk_nxt = pol_r;
          cnt_nxt  = second_len_r;
          bits_nxt = bits_r - BW'(1);
          if (!last_bit) begin
            mosi_nxt  = tx_sh_r[WORD_W-1];
            tx_sh_nxt = tx_sh_r << 1;
            state_nxt = spi_timing_pkg::ST_SECOND;
          end else begin
            rx_data_nxt  = rx_sh_r;
            rx_valid_nxt = 1'b1;
            if (run_en && tx_drain.valid) begin
              // Next word follows with the select held low.
              pop       = 1'b1;
              tx_sh_nxt = tx_drain.data << 1;
              mosi_nxt  = tx_drain.data[WORD_W-1];
              bits_nxt  = BW'(WORD_W);
              state_nxt = spi_timing_pkg::ST_SECOND;
            end else begin
              // Half a period after the last sampling edge.
              sel_b_nxt = `SELECT_IDLE_LEVEL;
              state_nxt = spi_timing_pkg::ST_IDLE;
            end
          end
        end
      end
      spi_timing_pkg::ST_SECOND: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_done) begin
          sclk_nxt  = ~pol_r;
          rx_sh_nxt = {rx_sh_r[WORD_W-2:0], MASTER_IN_PIN_I};
          cnt_nxt   = first_len_r;
          state_nxt = spi_timing_pkg::ST_FIRST;
        end
      end
      default: begin
        state_nxt = spi_timing_pkg::ST_IDLE;
      end
    endcase
  end

  assign tx_drain.ready = pop;

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      state_r      <= spi_timing_pkg::ST_IDLE;
      cnt_r        <= '0;
      first_len_r  <= '0;
      second_len_r <= '0;
      pol_r        <= 1'b0;
      bits_r       <= '0;
      tx_sh_r      <= '0;
      rx_sh_r      <= '0;
      rx_data_r    <= '0;
      rx_valid_r   <= 1'b0;
      sclk_r       <= 1'b0;
      mosi_r       <= `MOSI_RESET_LEVEL;
      sel_b_r      <= `SELECT_IDLE_LEVEL;
    end else begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      first_len_r  <= first_len_nxt;
      second_len_r <= second_len_nxt;
      pol_r        <= pol_nxt;
      bits_r       <= bits_nxt;
      tx_sh_r      <= tx_sh_nxt;
      rx_sh_r      <= rx_sh_nxt;
      rx_data_r    <= rx_data_nxt;
      rx_valid_r   <= rx_valid_nxt;
      sclk_r       <= sclk_nxt;
      mosi_r       <= mosi_nxt;
      sel_b_r      <= sel_b_nxt;
    end
  end

  assign SERIAL_CLOCK_PIN_O   = sclk_r;
  assign MASTER_OUT_PIN_O     = mosi_r;
  assign SLAVE_SELECT_PIN_B_O = sel_b_r;
  assign RX_DATA_O            = rx_data_r;
  assign RX_VALID_O           = rx_valid_r;
  assign BUSY_O               = (state_r != spi_timing_pkg::ST_IDLE);

endmodule // spi_master_clock_select_timing

// [hdl/spi_timing_cfg.svh]
/*
 * Constants of the master serial clock and select sequencer: control bit
 * positions, divider limits and timing counts.
 * Assumes it is included by bare name from design files only.
 */
`ifndef SPI_TIMING_CFG_SVH
`define SPI_TIMING_CFG_SVH

// Control bit positions within the operation and configuration registers.
`define OPCTL_MASTER_BIT     2
`define OPCTL_PHASE_BIT      3
`define CFGCTL_POLARITY_BIT  6

// Serial period, in peripheral clock periods, for the small divider values.
`define SERIAL_PERIOD_FIXED  8'h04
// Divider values up to this one use the fixed period.
`define DIVIDER_FIXED_LIMIT  7'h02
// Period limits, in peripheral clock periods.
`define SERIAL_PERIOD_MIN      4
`define SERIAL_PERIOD_MAX_EVEN 128
`define SERIAL_PERIOD_MIN_ODD  5
`define SERIAL_PERIOD_MAX_ODD  127

// Reset values of the pins and the word length and FIFO depth defaults.
`define SELECT_IDLE_LEVEL    1'b1
`define MOSI_RESET_LEVEL     1'b0
`define WORD_WIDTH_DEFAULT   8
`define FIFO_DEPTH_DEFAULT   8

`endif

// [hdl/spi_timing_pkg.sv]
/*
 * Types of the master serial clock and select sequencer.
 * Assumes nothing of its surroundings.
 */
package spi_timing_pkg;

  // Gray coded along idle, lead, first phase, second phase.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_LEAD   = 2'b01,
    ST_FIRST  = 2'b11,
    ST_SECOND = 2'b10
  } seq_state_e;

  typedef logic [7:0] period_t;

endpackage

// [hdl/word_fifo.sv]
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic   clk_i,
  input  wire logic   rst_b_i,
  word_stream_if.snk  fill,
  word_stream_if.src  drain
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    wr_nxt;
  logic [AW-1:0]    rd_r;
  logic [AW-1:0]    rd_nxt;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             push;
  logic             pop;

  assign fill.ready  = (cnt_r != (AW+1)'(DEPTH));
  assign drain.valid = (cnt_r != '0);
  assign drain.data  = mem_r[rd_r];
  assign push        = fill.valid & fill.ready;
  assign pop         = drain.valid & drain.ready;

  always_comb begin
    wr_nxt  = push ? ((wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1) : wr_r;
    rd_nxt  = pop ? ((rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1) : rd_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_r] <= fill.data;
    end
  end
endmodule // word_fifo

// [hdl/word_stream_if.sv]
/*
 * Valid/ready word stream into and out of the sequencer's transmit FIFO.
 * Assumes a single clock shared by both ends.
 */
interface word_stream_if #(
  parameter int WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input  ready);
  modport snk (input  valid, input  data, output ready);
endinterface

// [verif/spi_master_clock_select_timing_tb.sv]
/* Self-checking bench of the master serial sequencer.
   Assumes the slave model and the bound checker are compiled first. */
module spi_master_clock_select_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, rst_b = 1'b0, tx_v = 1'b0;
  logic [7:0] opc = 8'h00, cfg = 8'h00, tx_d = 8'h00, s_tx = 8'h00;
  logic [6:0] div = 7'h00;
  logic       tx_rdy, rx_v, busy, sck, mosi, miso, sel_b;
  logic [7:0] rx_d, s_got;
  int         errors = 0, checked = 0, cyc = 0, low = 0, len = 0;
  int         falls = 0, f0 = 0;
  logic [6:0] divs [6] = '{7'h00, 7'h02, 7'h03, 7'h04, 7'h7E, 7'h7F};
  always #2 clk = ~clk;
  spi_master_clock_select_timing dut (.REF_CLK_I(clk), .RST_B_I(rst_b),
    .OPERATION_CONTROL_REG_I(opc), .CONFIGURATION_CONTROL_REG_I(cfg),
    .BAUD_DIVIDER_I(div), .TX_DATA_I(tx_d), .TX_VALID_I(tx_v),
    .TX_READY_O(tx_rdy), .RX_DATA_O(rx_d), .RX_VALID_O(rx_v), .BUSY_O(busy),
    .SERIAL_CLOCK_PIN_O(sck), .MASTER_OUT_PIN_O(mosi),
    .MASTER_IN_PIN_I(miso), .SLAVE_SELECT_PIN_B_O(sel_b));
  spi_slave_model slave (.sclk_i(sck), .mosi_i(mosi), .sel_b_i(sel_b),
    .pol_i(cfg[6]), .tx_i(s_tx), .miso_o(miso), .got_o(s_got));
  // Measures select low time and select falls, and cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    low <= sel_b ? 0 : low + 1;
    if (!sel_b && low == 0) falls <= falls + 1;
    if (sel_b && low != 0) len <= low;
    if (cyc == 8000) begin
      errors++;
      end_sim();
    end
  end
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task push(input logic [7:0] w0, input int n);
    for (int i = 0; i < n; i++) begin
      tx_d <= w0 + 8'(i * 17);
      tx_v <= 1'b1;
      @(posedge clk);
      while (tx_rdy !== 1'b1) @(posedge clk);
    end
    tx_v <= 1'b0;
  endtask
  task take(input logic [7:0] w);
    for (int k = 0; k < 3000 && rx_v !== 1'b1; k++) @(posedge clk);
    cmp(rx_d, s_tx);
    cmp(s_got, w);
    @(posedge clk);
  endtask
  task end_sim;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    opc <= 8'h0C;
    for (int i = 0; i < 6; i++) begin
      div <= divs[i];
      cfg <= 8'(i % 2) << 6;
      s_tx <= 8'h5A + 8'(i);
      repeat (4) @(posedge clk);
      cmp(sck, cfg[6]);
      push(8'hC3 ^ 8'(i), 1);
      take(8'hC3 ^ 8'(i));
      cmp(len, divs[i] > 2 ? 8 * divs[i] + 8 : 32);
    end
    div <= 7'h00;
    opc <= 8'h04;
    push(8'h10, 8);
    @(posedge clk);
    cmp(tx_rdy, 0);
    for (int j = 0; j < 3; j++) begin
      opc <= 8'h04 << j;
      repeat (20) @(posedge clk);
      cmp({busy, sel_b}, 1);
    end
    f0 = falls;
    opc <= 8'h0C;
    for (int i = 0; i < 8; i++) take(8'h10 + 8'(i * 17));
    cmp(falls - f0, 1);
    cmp(len, 256);
    end_sim();
  end
endmodule // spi_master_clock_select_timing_tb

// [verif/spi_slave_model.sv]
/* Behavioural slave on the far side of the serial pins.
   Assumes it samples on the edge that leaves the idle level. */
module spi_slave_model (
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  input  wire logic       sel_b_i,
  input  wire logic       pol_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output logic [7:0]      got_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00;
  int         n  = 0;
  // A released line shows the inverse of the shift register's top bit sh[7], never a stale copy.
  assign miso_o = sel_b_i ? ~sh[7] : sh[7];
  always @(negedge sel_b_i) begin
    sh = tx_i;
    n  = 0;
  end
  always @(sclk_i) begin
    if (sclk_i != pol_i) begin
      got_o = {got_o[6:0], mosi_i};
      n     = n % 8 + 1;
    end else begin
      sh = (n == 8) ? tx_i : sh << 1;
    end
  end
endmodule // spi_slave_model

// [verif/spi_timing_sva.sv]
/* Timing assertions on the serial pins.
   Assumes it is bound to the sequencer top module. */
module spi_timing_sva (
  input wire logic       REF_CLK_I,
  input wire logic       RST_B_I,
  input wire logic [7:0] OPERATION_CONTROL_REG_I,
  input wire logic [7:0] CONFIGURATION_CONTROL_REG_I,
  input wire logic [6:0] BAUD_DIVIDER_I,
  input wire logic       TX_VALID_I,
  input wire logic       TX_READY_O,
  input wire logic       RX_VALID_O,
  input wire logic       BUSY_O,
  input wire logic       SERIAL_CLOCK_PIN_O,
  input wire logic       MASTER_OUT_PIN_O,
  input wire logic       SLAVE_SELECT_PIN_B_O
);
  timeunit 1ns;
  timeprecision 1ps;
  wire        sck = SERIAL_CLOCK_PIN_O;
  wire        sel = SLAVE_SELECT_PIN_B_O;
  wire        pol = CONFIGURATION_CONTROL_REG_I[6];
  wire        run = OPERATION_CONTROL_REG_I[2] & OPERATION_CONTROL_REG_I[3];
  logic [7:0] len_r, len_nxt, per;
  logic       sck_r, sel_r;
  // Words accepted by the FIFO and not yet handed back as received.
  logic [7:0] q_r;
  // Counts cycles since the last clock edge or select fall.
  always_comb begin
    per = BAUD_DIVIDER_I > 7'h02 ? {1'b0, BAUD_DIVIDER_I} + 8'h01 : 8'h04;
    len_nxt = (sck != sck_r || (sel_r && !sel)) ? 8'h01 : len_r + 8'h01;
  end
  always_ff @(posedge REF_CLK_I) begin
    len_r <= len_nxt;
    sck_r <= sck;
    sel_r <= sel;
    if (!RST_B_I) q_r <= 8'h00;
    else q_r <= q_r + 8'(TX_VALID_I & TX_READY_O) - 8'(RX_VALID_O);
  end
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);
  sel_idle_a: assert property (!BUSY_O |-> sel)
    else $error("select low when idle");
  clk_idle_a: assert property (
    !BUSY_O && !$past(BUSY_O) && $past(RST_B_I) && $stable(pol) |-> sck == pol)
    else $error("clock off idle level");
  rel_edge_a: assert property ($rose(sel) |-> $changed(sck) && RX_VALID_O)
    else $error("release off last edge");
  rx_pulse_a: assert property (RX_VALID_O |-> $changed(sck) ##1 !RX_VALID_O)
    else $error("receive pulse misplaced");
  data_edge_a: assert property (
    $changed(MASTER_OUT_PIN_O) && !sel && !$past(sel) |-> $changed(sck) && sck == pol)
    else $error("data changed off idle edge");
  queue_hold_a: assert property ($rose(sel) |-> q_r == 8'h01)
    else $error("select released with words queued");
  mode_gate_a: assert property (!BUSY_O && !run |=> !BUSY_O)
    else $error("word started while not enabled");
  phase_len_a: assert property (
    $changed(sck) && !$past(sel)
      |-> len_r == (sck == pol ? per >> 1 : per - (per >> 1)))
    else $error("clock phase length wrong");
endmodule // spi_timing_sva

bind spi_master_clock_select_timing spi_timing_sva sva (
  .REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I), .BUSY_O(BUSY_O),
  .OPERATION_CONTROL_REG_I(OPERATION_CONTROL_REG_I),
  .CONFIGURATION_CONTROL_REG_I(CONFIGURATION_CONTROL_REG_I),
  .BAUD_DIVIDER_I(BAUD_DIVIDER_I), .TX_READY_O(TX_READY_O),
  .TX_VALID_I(TX_VALID_I),
  .RX_VALID_O(RX_VALID_O), .SERIAL_CLOCK_PIN_O(SERIAL_CLOCK_PIN_O),
  .MASTER_OUT_PIN_O(MASTER_OUT_PIN_O),
  .SLAVE_SELECT_PIN_B_O(SLAVE_SELECT_PIN_B_O));
